// ==== common/tci_pkg.sv ====
// Package for the timer capture and interrupt register block.
// Assumes a 20 MHz core clock and a 32-bit Avalon-MM register port.
package tci_pkg;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned NUM_EVT  = 7;
  // Printed offsets are not all multiples of four: they are indices, byte address = 4 x index
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_A_VALUE    = 16'h4582;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_B_VALUE    = 16'h4584;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_B_CONFIG   = 16'h4594;
  localparam logic [ADDR_W-1:0] IDX_TIMER_IRQ_PENDING  = 16'h4614;
  localparam logic [ADDR_W-1:0] IDX_TIMER_IRQ_ENABLE   = 16'h462C;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_A_CONFIG   = 16'h4592;
  // Field positions
  localparam int unsigned CFG_FILT_BIT   = 8;
  localparam int unsigned CFG_EDGE_LSB   = 5;
  localparam int unsigned CFG_EDGE_MSB   = 6;
  localparam int unsigned T1_EVT_LSB     = 0;
  localparam int unsigned T2_EVT_LSB     = 8;
  // Event order inside each timer's seven-bit group
  localparam int unsigned EVT_OVF  = 0;
  localparam int unsigned EVT_CMPA = 1;
  localparam int unsigned EVT_CMPB = 2;
  localparam int unsigned EVT_CMPZ = 3;
  localparam int unsigned EVT_CMPT = 4;
  localparam int unsigned EVT_CAPA = 5;
  localparam int unsigned EVT_CAPB = 6;
  // Reset values and masks
  localparam logic [15:0] RST_CAPTURE_VALUE = 16'h0000;
  localparam logic [15:0] RST_CAPTURE_CFG   = 16'h0000;
  localparam logic [15:0] RST_IRQ           = 16'h0000;
  localparam logic [15:0] IRQ_MASK          = 16'h7F7F;
  localparam logic [15:0] CFG_MASK          = 16'h0160;
  // Edge select encodings
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Input filter: input must hold steady this long before it is accepted
  localparam int unsigned FILTER_TIME_NS = 200;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned FILTER_CYCLES  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  FILTER_CNT     = 3'(FILTER_CYCLES);
endpackage : tci_pkg

// ==== src/tci_capture_chan.sv ====
// One capture channel: synchroniser, optional glitch filter, edge select, value latch.
// Assumes the input pin is asynchronous to core_clk.
`timescale 1ns/100ps
module tci_capture_chan
  import tci_pkg::*;
(
  input  wire logic             core_clk,   // Core clock
  input  wire logic             arst_n,     // Async reset, active low
  input  wire logic             capPin,     // Raw capture pin
  input  wire logic             filtEn,     // Filter enable
  input  wire logic [1:0]       edgeSel,    // Edge selection
  input  wire logic [CNT_W-1:0] count,      // Counter value
  output logic                  capEvent,   // One-cycle capture pulse
  output logic      [CNT_W-1:0] capValue    // Last captured value
);
  logic       sync1Reg;
  logic       sync2Reg;
  logic       filtReg;
  logic [2:0] stableReg;
  logic       levelReg;
  logic       cleanLevel;
  logic       rise;
  logic       fall;
  logic       hit;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1Reg <= 1'b0;
      sync2Reg <= 1'b0;
    end else begin
      sync1Reg <= capPin;
      sync2Reg <= sync1Reg;
    end
  end

  // Filtered level follows the input only after it stays put long enough
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      filtReg   <= 1'b0;
      stableReg <= 3'h0;
    end else if (sync2Reg == filtReg) begin
      stableReg <= 3'h0;
    end else if (stableReg == FILTER_CNT - 3'h1) begin
      filtReg   <= sync2Reg;
      stableReg <= 3'h0;
    end else begin
      stableReg <= stableReg + 3'h1;
    end
  end

  assign cleanLevel = filtEn ? filtReg : sync2Reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      levelReg <= 1'b0;
    end else begin
      levelReg <= cleanLevel;
    end
  end

  assign rise = cleanLevel & ~levelReg;
  assign fall = ~cleanLevel & levelReg;

  always_comb begin
    case (edgeSel)
      EDGE_OFF:  hit = 1'b0;
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      default:   hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capEvent <= 1'b0;
      capValue <= RST_CAPTURE_VALUE;
    end else begin
      capEvent <= hit;
      if (hit) begin
        capValue <= count;
      end
    end
  end

  a_capture_latch: assert property (@(posedge core_clk) disable iff (!arst_n)
    hit |=> capEvent && capValue == $past(count))
    else $error("capture value not latched on edge");
  a_capture_off: assert property (@(posedge core_clk) disable iff (!arst_n)
    edgeSel == EDGE_OFF |=> !capEvent)
    else $error("capture fired while disabled");
  a_capture_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
    (edgeSel == EDGE_RISE && !filtEn && sync2Reg && !levelReg) |=> capEvent)
    else $error("rising edge missed");
  a_capture_fall: assert property (@(posedge core_clk) disable iff (!arst_n)
    (edgeSel == EDGE_FALL && rise && !fall) |=> !capEvent)
    else $error("rising edge captured in falling mode");
  a_filter_bypass: assert property (@(posedge core_clk) disable iff (!arst_n)
    !filtEn |-> cleanLevel == sync2Reg)
    else $error("filter not bypassed");
  a_filter_glitch: assert property (@(posedge core_clk) disable iff (!arst_n)
    (filtEn && sync2Reg != filtReg) ##1 (sync2Reg == filtReg) |=> $stable(filtReg))
    else $error("one-cycle glitch passed filter");
  c_both_edges: cover property (@(posedge core_clk) disable iff (!arst_n)
    edgeSel == EDGE_BOTH && fall ##1 capEvent);
endmodule : tci_capture_chan

// ==== src/tci_capture_irq_regs.sv ====
// Timer capture channels A and B plus shared interrupt enable and pending registers.
// Assumes an Avalon-MM master on core_clk, word addressed with byte address = 4 x index.
`timescale 1ns/100ps
module tci_capture_irq_regs
  import tci_pkg::*;
(
  input  wire logic                 core_clk,        // Core clock, 20 MHz
  input  wire logic                 arst_n,          // Async reset, active low
  input  wire logic [ADDR_W+1:0]    avs_address,     // Byte address
  input  wire logic                 avs_read,        // Read request
  input  wire logic                 avs_write,       // Write request
  input  wire logic [DATA_W-1:0]    avs_writedata,   // Write data
  input  wire logic [3:0]           avs_byteenable,  // Byte enables
  output logic      [DATA_W-1:0]    avs_readdata,    // Read data
  output logic                      avs_waitrequest, // Wait request
  output logic      [1:0]           avs_response,    // 00 okay, 10 slave error
  input  wire logic [CNT_W-1:0]     t2Count,         // Timer 2 counter value
  input  wire logic                 capPinA,         // Capture A pin
  input  wire logic                 capPinB,         // Capture B pin
  input  wire logic [NUM_EVT-1:0]   t1Events,        // Timer 1 event strobes
  input  wire logic [4:0]           t2Events,        // Timer 2 overflow..top strobes
  output logic                      timerIrq,        // Interrupt request
  output logic      [15:0]          capAConfig,      // Capture A config for filters
  output logic      [15:0]          capBConfig       // Capture B config
);
  logic [15:0]        capACfgReg;
  logic [15:0]        capBCfgReg;
  logic [15:0]        enableReg;
  logic [15:0]        pendingReg;
  logic [15:0]        pendingNext;
  logic [CNT_W-1:0]   capAValue;
  logic [CNT_W-1:0]   capBValue;
  logic               capAEvent;
  logic               capBEvent;
  logic [15:0]        eventVec;
  logic [ADDR_W-1:0]  index;
  logic               wordAligned;
  logic               accessHit;
  logic               ackReg;
  logic [15:0]        wMask;
  logic               wrStrobe;
  logic [15:0]        rdData;
  logic               rdHit;

  assign index       = avs_address[ADDR_W+1:2];
  assign wordAligned = avs_address[1:0] == 2'h0;
  assign wMask       = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  tci_capture_chan u_cap_a (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .capPin   (capPinA),
    .filtEn   (capACfgReg[CFG_FILT_BIT]),
    .edgeSel  (capACfgReg[CFG_EDGE_MSB:CFG_EDGE_LSB]),
    .count    (t2Count),
    .capEvent (capAEvent),
    .capValue (capAValue)
  );

  tci_capture_chan u_cap_b (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .capPin   (capPinB),
    .filtEn   (capBCfgReg[CFG_FILT_BIT]),
    .edgeSel  (capBCfgReg[CFG_EDGE_MSB:CFG_EDGE_LSB]),
    .count    (t2Count),
    .capEvent (capBEvent),
    .capValue (capBValue)
  );

  // Event vector in register layout
  always_comb begin
    eventVec = 16'h0000;
    eventVec[T1_EVT_LSB +: NUM_EVT]      = t1Events;
    eventVec[T2_EVT_LSB +: 5]            = t2Events;
    eventVec[T2_EVT_LSB + EVT_CAPA]      = capAEvent;
    eventVec[T2_EVT_LSB + EVT_CAPB]      = capBEvent;
  end

  // Register decode
  always_comb begin
    rdHit  = 1'b1;
    rdData = 16'h0000;
    case (index)
      IDX_CAPTURE_A_VALUE:   rdData = capAValue;
      IDX_CAPTURE_B_VALUE:   rdData = capBValue;
      IDX_CAPTURE_A_CONFIG:  rdData = capACfgReg;
      IDX_CAPTURE_B_CONFIG:  rdData = capBCfgReg;
      IDX_TIMER_IRQ_PENDING: rdData = pendingReg;
      IDX_TIMER_IRQ_ENABLE:  rdData = enableReg;
      default:               rdHit  = 1'b0;
    endcase
  end

  assign accessHit = rdHit && wordAligned;
  // Writes land at the edge where the master samples waitrequest low
  assign wrStrobe  = avs_write && ackReg && accessHit;

  // One wait cycle, then acknowledge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= (avs_read || avs_write) && !ackReg;
    end
  end

  // Registered copy of the inverted next acknowledge, so the port comes from a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ackReg);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end else if ((avs_read || avs_write) && !ackReg) begin
      avs_readdata <= avs_read && accessHit ? {16'h0000, rdData} : '0;
      avs_response <= accessHit ? 2'h0 : 2'h2;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capACfgReg <= RST_CAPTURE_CFG;
      capBCfgReg <= RST_CAPTURE_CFG;
    end else if (wrStrobe) begin
      if (index == IDX_CAPTURE_A_CONFIG) begin
        capACfgReg <= (capACfgReg & ~(wMask & CFG_MASK)) | (avs_writedata[15:0] & wMask & CFG_MASK);
      end
      if (index == IDX_CAPTURE_B_CONFIG) begin
        capBCfgReg <= (capBCfgReg & ~(wMask & CFG_MASK)) | (avs_writedata[15:0] & wMask & CFG_MASK);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enableReg <= RST_IRQ;
    end else if (wrStrobe && index == IDX_TIMER_IRQ_ENABLE) begin
      enableReg <= (enableReg & ~(wMask & IRQ_MASK)) | (avs_writedata[15:0] & wMask & IRQ_MASK);
    end
  end

  // Write one clears; a new event in the same cycle wins
  always_comb begin
    pendingNext = pendingReg;
    if (wrStrobe && index == IDX_TIMER_IRQ_PENDING) begin
      pendingNext = pendingReg & ~(avs_writedata[15:0] & wMask);
    end
    pendingNext = (pendingNext | eventVec) & IRQ_MASK;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pendingReg <= RST_IRQ;
    end else begin
      pendingReg <= pendingNext;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= |(pendingNext & enableReg);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capAConfig <= RST_CAPTURE_CFG;
      capBConfig <= RST_CAPTURE_CFG;
    end else begin
      capAConfig <= capACfgReg;
      capBConfig <= capBCfgReg;
    end
  end

  a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 timerIrq == |($past(pendingNext) & $past(enableReg)))
    else $error("interrupt level wrong");
  a_t2_capa_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    capAEvent |=> pendingReg[T2_EVT_LSB + EVT_CAPA])
    else $error("capture A pending not set");
  a_t1_capb_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    t1Events[EVT_CAPB] |=> pendingReg[EVT_CAPB])
    else $error("timer 1 capture B pending not set");
  a_pending_reserved: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pendingReg & ~IRQ_MASK) == 16'h0000 && (enableReg & ~IRQ_MASK) == 16'h0000)
    else $error("reserved interrupt bit set");
  a_enable_t1_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wrStrobe && index == IDX_TIMER_IRQ_ENABLE && avs_byteenable[0])
      |=> enableReg[6:0] == $past(avs_writedata[6:0]))
    else $error("timer 1 enable not written");
  a_enable_t2_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wrStrobe && index == IDX_TIMER_IRQ_ENABLE && avs_byteenable[1])
      |=> enableReg[14:8] == $past(avs_writedata[14:8]))
    else $error("timer 2 enable not written");
  a_wait_bounded: assert property (@(posedge core_clk) disable iff (!arst_n)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("waitrequest held too long");
  c_irq_raised: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(timerIrq));
  c_clear_pending: cover property (@(posedge core_clk) disable iff (!arst_n)
    wrStrobe && index == IDX_TIMER_IRQ_PENDING && pendingReg != 16'h0000);
  c_capture_b: cover property (@(posedge core_clk) disable iff (!arst_n) capBEvent);
endmodule : tci_capture_irq_regs

// ==== dv/tci_testbench.sv ====
// Self-checking testbench for the timer capture and interrupt register block.
// Assumes the tci_pkg package and a 20 MHz core clock; the bench drives every pin itself.
`timescale 1ns/100ps
module testbench;
  import tci_pkg::*;

  logic                 core_clk;
  logic                 arst_n;
  logic [ADDR_W+1:0]    avsAddress;
  logic                 avsRead;
  logic                 avsWrite;
  logic [DATA_W-1:0]    avsWritedata;
  logic [DATA_W-1:0]    avsReaddata;
  logic                 avsWaitrequest;
  logic [1:0]           avsResponse;
  logic [CNT_W-1:0]     t2Count;
  logic                 capPinA;
  logic                 capPinB;
  logic [NUM_EVT-1:0]   t1Events;
  logic [4:0]           t2Events;
  logic                 timerIrq;
  int                   badCount;
  int                   nChecks;

  tci_capture_irq_regs u_tci_capture_irq_regs (
    .core_clk        (core_clk),
    .arst_n          (arst_n),
    .avs_address     (avsAddress),
    .avs_read        (avsRead),
    .avs_write       (avsWrite),
    .avs_writedata   (avsWritedata),
    .avs_byteenable  (4'hF),
    .avs_readdata    (avsReaddata),
    .avs_waitrequest (avsWaitrequest),
    .avs_response    (avsResponse),
    .t2Count         (t2Count),
    .capPinA         (capPinA),
    .capPinB         (capPinB),
    .t1Events        (t1Events),
    .t2Events        (t2Events),
    .timerIrq        (timerIrq),
    .capAConfig      (),
    .capBConfig      ()
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic conclude();
    if (badCount == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon transfer: request held until waitrequest is sampled low
  task automatic avAccess(input logic [15:0] idx, input logic wr, input logic [15:0] wdata,
                          output logic [31:0] rdata, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress   <= {idx, 2'b00};
    avsWrite     <= wr;
    avsRead      <= ~wr;
    avsWritedata <= {16'h0000, wdata};
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 100);
    if (n >= 100) check(32'h0000_0000, 32'hFFFF_FFFF);
    rdata = avsReaddata;
    resp  = avsResponse;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask : avAccess

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic [1:0]  s;
    avAccess(idx, 1'b1, d, r, s);
  endtask : wr

  task automatic rdCheck(input logic [15:0] idx, input logic [15:0] exp);
    logic [31:0] r;
    logic [1:0]  s;
    avAccess(idx, 1'b0, 16'h0000, r, s);
    check(r, {16'h0000, exp});
  endtask : rdCheck

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : settle

  task automatic testResetAndLayout();
    logic [31:0] r;
    logic [1:0]  s;
    rdCheck(IDX_CAPTURE_A_VALUE, 16'h0000);
    rdCheck(IDX_CAPTURE_B_VALUE, 16'h0000);
    rdCheck(IDX_CAPTURE_B_CONFIG, 16'h0000);
    rdCheck(IDX_TIMER_IRQ_PENDING, 16'h0000);
    rdCheck(IDX_TIMER_IRQ_ENABLE, 16'h0000);
    avAccess(16'h4000, 1'b0, 16'h0000, r, s);
    check({30'h0, s}, 32'h0000_0002);
    wr(IDX_TIMER_IRQ_ENABLE, 16'hFFFF);
    rdCheck(IDX_TIMER_IRQ_ENABLE, 16'h7F7F);
    wr(IDX_TIMER_IRQ_ENABLE, 16'h0000);
    wr(IDX_CAPTURE_B_CONFIG, 16'hFFFF);
    rdCheck(IDX_CAPTURE_B_CONFIG, 16'h0160);
    wr(IDX_CAPTURE_B_VALUE, 16'hFFFF);
    rdCheck(IDX_CAPTURE_B_VALUE, 16'h0000);
  endtask : testResetAndLayout

  // Each strobe lands in its own pending bit and is cleared by writing one
  task automatic testEvents();
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      if (i < 7) t1Events <= 7'(1 << i);
      else t2Events <= 5'(1 << (i - 7));
      @(posedge core_clk);
      t1Events <= '0;
      t2Events <= '0;
      if (i < 7) rdCheck(IDX_TIMER_IRQ_PENDING, 16'(1 << i));
      else rdCheck(IDX_TIMER_IRQ_PENDING, 16'(1 << (i + 1)));
      wr(IDX_TIMER_IRQ_PENDING, 16'hFFFF);
      rdCheck(IDX_TIMER_IRQ_PENDING, 16'h0000);
    end
  endtask : testEvents

  task automatic irqLevel(input logic exp);
    settle(2);
    @(negedge core_clk);
    check({31'h0, timerIrq}, {31'h0, exp});
  endtask : irqLevel

  task automatic testIrq();
    @(posedge core_clk);
    t1Events <= 7'h20;
    t2Events <= 5'h01;
    @(posedge core_clk);
    t1Events <= '0;
    t2Events <= '0;
    irqLevel(1'b0);
    wr(IDX_TIMER_IRQ_ENABLE, 16'h0020);
    irqLevel(1'b1);
    wr(IDX_TIMER_IRQ_PENDING, 16'h0020);
    irqLevel(1'b0);
    wr(IDX_TIMER_IRQ_ENABLE, 16'h0100);
    irqLevel(1'b1);
    wr(IDX_TIMER_IRQ_ENABLE, 16'h0000);
    irqLevel(1'b0);
    wr(IDX_TIMER_IRQ_PENDING, 16'hFFFF);
  endtask : testIrq

  // Every edge mode on channel B, a rising then a falling edge each
  task automatic testEdgeModes();
    logic [15:0] expB;
    expB = 16'h0000;
    for (int m = 0; m < 4; m++) begin
      wr(IDX_CAPTURE_B_CONFIG, 16'(m << CFG_EDGE_LSB));
      t2Count <= 16'h1000 + 16'(m * 2);
      capPinB <= 1'b1;
      settle(12);
      if (m[0]) expB = 16'h1000 + 16'(m * 2);
      rdCheck(IDX_CAPTURE_B_VALUE, expB);
      t2Count <= 16'h2001 + 16'(m * 2);
      capPinB <= 1'b0;
      settle(12);
      if (m[1]) expB = 16'h2001 + 16'(m * 2);
      rdCheck(IDX_CAPTURE_B_VALUE, expB);
      rdCheck(IDX_TIMER_IRQ_PENDING, (m != 0) ? 16'h4000 : 16'h0000);
      wr(IDX_TIMER_IRQ_PENDING, 16'h4000);
    end
  endtask : testEdgeModes

  task automatic pulseA(input logic [15:0] cnt, input int width);
    t2Count <= cnt;
    capPinA <= 1'b1;
    settle(width);
    capPinA <= 1'b0;
    settle(12);
  endtask : pulseA

  // A short glitch is dropped only while the filter is on
  task automatic testFilter();
    wr(IDX_CAPTURE_A_CONFIG, 16'h0120);
    pulseA(16'hA5A5, 2);
    rdCheck(IDX_CAPTURE_A_VALUE, 16'h0000);
    pulseA(16'h5A5A, 10);
    rdCheck(IDX_CAPTURE_A_VALUE, 16'h5A5A);
    wr(IDX_CAPTURE_A_CONFIG, 16'h0020);
    pulseA(16'h3C3C, 2);
    rdCheck(IDX_CAPTURE_A_VALUE, 16'h3C3C);
    rdCheck(IDX_TIMER_IRQ_PENDING, 16'h2000);
    wr(IDX_TIMER_IRQ_PENDING, 16'h2000);
  endtask : testFilter

  initial begin
    settle(20000);
    badCount++;
    conclude();
  end

  initial begin
    badCount     = 0;
    nChecks      = 0;
    arst_n       = 1'b0;
    avsAddress   = '0;
    avsRead      = 1'b0;
    avsWrite     = 1'b0;
    avsWritedata = '0;
    t2Count      = 16'h0000;
    capPinA      = 1'b0;
    capPinB      = 1'b0;
    t1Events     = '0;
    t2Events     = '0;
    settle(20);
    arst_n <= 1'b1;
    testResetAndLayout();
    testEvents();
    testIrq();
    testEdgeModes();
    testFilter();
    conclude();
  end
endmodule : testbench
